// [hdl/csac_defines.vh]
// constants for the card sector access control block
//
// Function
// RULE_01 - sixteen sectors of four blocks each
// RULE_02 - last block of sector is trailer
// RULE_03 - trailer bytes 0..5 hold first key
// RULE_04 - trailer bytes 10..15 hold second key
// RULE_05 - trailer bytes 6..9 hold access conditions
// RULE_06 - per block, per key operation permissions
// RULE_07 - no value operations on trailer blocks
// RULE_08 - access bits redundant, corruption detected
// RULE_09 - enabled keys read back as zero
// RULE_10 - each block value or data configurable
// RULE_11 - decode access bytes into block types
// RULE_12 - second key may rewrite example trailers
// RULE_13 - sector 0 block 0 never writable
// RULE_14 - delivery setting: first key full, second disabled
// RULE_15 - reader rewrites trailer only when safe
// RULE_16 - authenticate first, other sector fails
`ifndef CSAC_DEFINES_VH
`define CSAC_DEFINES_VH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define CSAC_OFS_CMD      8'h00
`define CSAC_OFS_STAT     8'h04
`define CSAC_OFS_KEY_LO   8'h08
`define CSAC_OFS_KEY_HI   8'h0C
`define CSAC_OFS_DATA0    8'h10
`define CSAC_OFS_DATA1    8'h14
`define CSAC_OFS_DATA2    8'h18
`define CSAC_OFS_DATA3    8'h1C

// ---------------------------------------------------------------
// command word opcodes
// ---------------------------------------------------------------
`define CSAC_OP_AUTH      3'h0
`define CSAC_OP_READ      3'h1
`define CSAC_OP_WRITE     3'h2
`define CSAC_OP_INC       3'h3
`define CSAC_OP_DEC       3'h4
`define CSAC_OP_RESTORE   3'h5

// ---------------------------------------------------------------
// error codes in status
// ---------------------------------------------------------------
`define CSAC_ERR_NONE     4'h0
`define CSAC_ERR_AUTH     4'h1
`define CSAC_ERR_PERM     4'h2
`define CSAC_ERR_KEY      4'h3
`define CSAC_ERR_CORRUPT  4'h4
`define CSAC_ERR_VALUE    4'h5
`define CSAC_ERR_OP       4'h6

// ---------------------------------------------------------------
// delivery contents
// ---------------------------------------------------------------
`define CSAC_RST_KEY      48'hFFFF_FFFF_FFFF
`define CSAC_RST_ACC      32'h6980_07FF

`endif

// [hdl/csac_top.v]
// card sector access control with an AHB-Lite register slave
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register addresses.
`include "csac_defines.vh"

module csac_top #(
	parameter [127:0] SERIAL_BLK = 128'h0000_0000_0000_0000_0000_0000_1234_5678
) (
	// clock and reset
	input  wire         clk_i,
	input  wire         sys_rst_i,
	// ahb-lite slave
	input  wire         hsel_i,
	input  wire [31:0]  haddr_i,
	input  wire [1:0]   htrans_i,
	input  wire         hwrite_i,
	input  wire [2:0]   hsize_i,
	input  wire [31:0]  hwdata_i,
	input  wire         hready_i,
	output wire [31:0]  hrdata_o,
	output wire         hreadyout_o,
	output wire         hresp_o
);

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	reg  [127:0] mem_r [0:63];
	reg  [31:0]  hrdata_r;
	reg          hreadyout_r;
	reg          wr_pend_r;
	reg          rd_pend_r;
	reg  [7:0]   addr_r;
	reg  [47:0]  key_r;
	reg  [127:0] data_r;
	reg          auth_v_r;
	reg          auth_k_r;
	reg  [3:0]   auth_sec_r;
	reg          ok_r;
	reg          fail_r;
	reg  [3:0]   err_r;
	integer      i;

	// ---------------------------------------------------------------
	// command decode
	// ---------------------------------------------------------------
	wire         cmd_go = wr_pend_r && (addr_r == `CSAC_OFS_CMD);
	wire [2:0]   c_op   = hwdata_i[2:0];
	wire [5:0]   c_blk  = hwdata_i[13:8];
	wire         c_kb   = hwdata_i[16];
	wire [5:0]   c_dst  = hwdata_i[29:24];
	wire [127:0] src    = mem_r[c_blk];
	wire [127:0] trl    = mem_r[{c_blk[5:2], 2'b11}];  // see RULE_02
	wire [7:0]   b6     = trl[55:48];                 // see RULE_05
	wire [7:0]   b7     = trl[63:56];
	wire [7:0]   b8     = trl[71:64];
	wire [3:0]   c1     = b7[7:4];
	wire [3:0]   c2     = b8[3:0];
	wire [3:0]   c3     = b8[7:4];
	// inverted copies must match the plain ones
	wire         acc_ok = (c1 == ~b6[3:0]) && (c2 == ~b6[7:4]) &&
	                      (c3 == ~b7[3:0]);          // see RULE_08
	wire [1:0]   sj     = c_blk[1:0];
	wire [1:0]   dj     = c_dst[1:0];
	wire [2:0]   cs     = {c1[sj], c2[sj], c3[sj]};   // see RULE_11
	wire [2:0]   cd     = {c1[dj], c2[dj], c3[dj]};
	wire [2:0]   ct     = {c1[3], c2[3], c3[3]};
	// second key readable means it cannot be used as a key
	wire         kb_rd  = (ct == 3'b000) || (ct == 3'b010) ||
	                      (ct == 3'b001);             // see RULE_14
	wire         tw_key = (((ct == 3'b000) || (ct == 3'b001)) && !auth_k_r) ||
	                      (((ct == 3'b100) || (ct == 3'b011)) && auth_k_r);
	wire         tw_acc = ((ct == 3'b001) && !auth_k_r) ||
	                      (((ct == 3'b011) || (ct == 3'b101)) && auth_k_r);
	wire [31:0]  sv     = src[31:0];
	wire [7:0]   sa     = src[103:96];
	wire         sv_ok  = (src[63:32] == ~sv) && (src[95:64] == sv) &&
	                      (src[111:104] == ~sa) && (src[119:112] == sa) &&
	                      (src[127:120] == ~sa);

	// data block permission; op 0 read, 1 write, 2 inc, 3 dec/restore
	function dperm;
		input [2:0] c;
		input       kb;
		input [1:0] op;
		begin
			case (c)
				3'b000: dperm = 1'b1;
				3'b010: dperm = (op == 2'd0);
				3'b100: dperm = (op == 2'd0) || ((op == 2'd1) && kb);
				3'b110: dperm = (op == 2'd0) || (op == 2'd3) ||
				                (kb && ((op == 2'd1) || (op == 2'd2)));
				3'b001: dperm = (op == 2'd0) || (op == 2'd3);
				3'b011: dperm = kb && ((op == 2'd0) || (op == 2'd1));
				3'b101: dperm = kb && (op == 2'd0);
				default: dperm = 1'b0;
			endcase
		end
	endfunction

	// ---------------------------------------------------------------
	// command execution
	// ---------------------------------------------------------------
	reg          x_ok;
	reg  [3:0]   x_err;
	reg          m_we;
	reg  [5:0]   m_addr;
	reg  [127:0] m_wd;
	reg          d_ld;
	reg  [127:0] d_val;
	reg          a_set;
	reg          a_clr;
	reg  [31:0]  nv;
	reg  [1:0]   vop;

	always @*
	begin
		x_ok   = 1'b0;
		x_err  = `CSAC_ERR_NONE;
		m_we   = 1'b0;
		m_addr = c_blk;
		m_wd   = data_r;
		d_ld   = 1'b0;
		d_val  = 128'h0;
		a_set  = 1'b0;
		a_clr  = 1'b0;
		nv     = sv;
		vop    = 2'd3;
		if (c_op == `CSAC_OP_AUTH)
		begin
			a_clr = 1'b1;
			if (!acc_ok)
				x_err = `CSAC_ERR_CORRUPT;                    // see RULE_08
			else if (c_kb && kb_rd)
				x_err = `CSAC_ERR_KEY;                        // see RULE_14
			else if (key_r != (c_kb ? trl[127:80] : trl[47:0]))
				x_err = `CSAC_ERR_KEY;                        // see RULE_03 RULE_04
			else
			begin
				a_set = 1'b1;
				x_ok  = 1'b1;
			end
		end
		else if (!auth_v_r || (c_blk[5:2] != auth_sec_r))
			x_err = `CSAC_ERR_AUTH;                           // see RULE_16
		else if (!acc_ok)
			x_err = `CSAC_ERR_CORRUPT;                        // see RULE_08
		else
		begin
			case (c_op)
				`CSAC_OP_READ:
				begin
					x_ok = 1'b1;
					d_ld = 1'b1;
					if (sj == 2'd3)
						d_val = {kb_rd ? trl[127:80] : 48'h0,
						         trl[79:48], 48'h0};          // see RULE_09
					else if (dperm(cs, auth_k_r, 2'd0))    // see RULE_06
						d_val = src;
					else
					begin
						x_ok  = 1'b0;
						x_err = `CSAC_ERR_PERM;
					end
				end
				`CSAC_OP_WRITE:
				begin
					if (c_blk == 6'd0)
						x_err = `CSAC_ERR_PERM;                   // see RULE_13
					else if (sj == 2'd3)
					begin
						if (tw_key || tw_acc)                   // see RULE_12
						begin
							x_ok = 1'b1;
							m_we = 1'b1;
							m_wd = {tw_key ? data_r[127:80] : trl[127:80],
							        tw_acc ? data_r[79:48] : trl[79:48],
							        tw_key ? data_r[47:0] : trl[47:0]};
						end
						else
							x_err = `CSAC_ERR_PERM;
					end
					else if (dperm(cs, auth_k_r, 2'd1))       // see RULE_06
					begin
						x_ok = 1'b1;
						m_we = 1'b1;
					end
					else
						x_err = `CSAC_ERR_PERM;
				end
				`CSAC_OP_INC, `CSAC_OP_DEC, `CSAC_OP_RESTORE:
				begin
					if (c_op == `CSAC_OP_INC)
					begin
						vop = 2'd2;
						nv  = sv + data_r[31:0];
					end
					else if (c_op == `CSAC_OP_DEC)
						nv = sv - data_r[31:0];
					m_addr = c_dst;
					m_wd   = {~sa, sa, ~sa, sa, nv, ~nv, nv};    // see RULE_10
					if ((sj == 2'd3) || (dj == 2'd3))
						x_err = `CSAC_ERR_OP;                     // see RULE_07
					else if ((c_dst[5:2] != c_blk[5:2]) || (c_dst == 6'd0))
						x_err = `CSAC_ERR_PERM;                   // see RULE_13 RULE_16
					else if (!dperm(cs, auth_k_r, vop) ||
					         !dperm(cd, auth_k_r, vop))
						x_err = `CSAC_ERR_PERM;                   // see RULE_06
					else if (!sv_ok)
						x_err = `CSAC_ERR_VALUE;
					else
					begin
						x_ok = 1'b1;
						m_we = 1'b1;
					end
				end
				default: x_err = `CSAC_ERR_OP;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// register read mux
	// ---------------------------------------------------------------
	reg [31:0] rd_mux;

	always @*
	begin
		case (addr_r)
			`CSAC_OFS_STAT:   rd_mux = {12'h0, err_r, 4'h0, auth_sec_r,
			                            3'h0, auth_k_r, auth_v_r, fail_r,
			                            ok_r, 1'b0};
			`CSAC_OFS_KEY_LO: rd_mux = key_r[31:0];
			`CSAC_OFS_KEY_HI: rd_mux = {16'h0, key_r[47:32]};
			`CSAC_OFS_DATA0:  rd_mux = data_r[31:0];
			`CSAC_OFS_DATA1:  rd_mux = data_r[63:32];
			`CSAC_OFS_DATA2:  rd_mux = data_r[95:64];
			`CSAC_OFS_DATA3:  rd_mux = data_r[127:96];
			default:          rd_mux = 32'h0;
		endcase
	end

	// ---------------------------------------------------------------
	// bus slave and state update
	// ---------------------------------------------------------------
	wire addr_ph = hsel_i && htrans_i[1] && hready_i;

	always @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			hrdata_r    <= 32'h0;
			hreadyout_r <= 1'b1;
			wr_pend_r   <= 1'b0;
			rd_pend_r   <= 1'b0;
			addr_r      <= 8'h0;
			key_r       <= 48'h0;
			data_r      <= 128'h0;
			auth_v_r    <= 1'b0;
			auth_k_r    <= 1'b0;
			auth_sec_r  <= 4'h0;
			ok_r        <= 1'b0;
			fail_r      <= 1'b0;
			err_r       <= `CSAC_ERR_NONE;
			// delivery image, sixteen sectors of four blocks
			for (i = 0; i < 64; i = i + 1)                    // see RULE_01
				mem_r[i] <= (i[1:0] == 2'd3) ?
				            {`CSAC_RST_KEY, `CSAC_RST_ACC, `CSAC_RST_KEY} :
				            128'h0;
			mem_r[0] <= SERIAL_BLK;                           // see RULE_13
		end
		else
		begin
			wr_pend_r <= addr_ph && hwrite_i;
			if (addr_ph)
				addr_r <= {haddr_i[7:2], 2'b00};
			// reads take one wait state so a preceding write settles
			rd_pend_r   <= addr_ph && !hwrite_i;
			hreadyout_r <= !(addr_ph && !hwrite_i);
			if (rd_pend_r)
				hrdata_r <= rd_mux;
			if (wr_pend_r)
			begin
				case (addr_r)
					`CSAC_OFS_KEY_LO: key_r[31:0]    <= hwdata_i;
					`CSAC_OFS_KEY_HI: key_r[47:32]   <= hwdata_i[15:0];
					`CSAC_OFS_DATA0:  data_r[31:0]   <= hwdata_i;
					`CSAC_OFS_DATA1:  data_r[63:32]  <= hwdata_i;
					`CSAC_OFS_DATA2:  data_r[95:64]  <= hwdata_i;
					`CSAC_OFS_DATA3:  data_r[127:96] <= hwdata_i;
					default: ;
				endcase
			end
			if (cmd_go)
			begin
				ok_r   <= x_ok;
				fail_r <= !x_ok;
				err_r  <= x_err;
				if (m_we)
					mem_r[m_addr] <= m_wd;
				if (d_ld)
					data_r <= d_val;
				if (a_set)
				begin
					auth_v_r   <= 1'b1;
					auth_k_r   <= c_kb;
					auth_sec_r <= c_blk[5:2];
				end
				else if (a_clr)
					auth_v_r <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign hrdata_o    = hrdata_r;
	assign hreadyout_o = hreadyout_r;
	assign hresp_o     = 1'b0;

endmodule // csac_top

// [dv/csac_top_properties.sv]
// bus-side assertions for csac_top
module csac_chk (
	// clock and reset
	input logic        clk_i,
	input logic        sys_rst_i,
	// ahb-lite side
	input logic        hsel_i,
	input logic [31:0] haddr_i,
	input logic [1:0]  htrans_i,
	input logic        hwrite_i,
	input logic [2:0]  hsize_i,
	input logic [31:0] hwdata_i,
	input logic        hready_i,
	input logic [31:0] hrdata_o,
	input logic        hreadyout_o,
	input logic        hresp_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic rd_acc;
	logic wr_acc;
	assign rd_acc = hsel_i && htrans_i[1] && hready_i && !hwrite_i;
	assign wr_acc = hsel_i && htrans_i[1] && hready_i && hwrite_i;
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	resp_always_okay_a: assert property (hresp_o == 1'b0)
		else $error("hresp not okay");
	read_one_wait_a: assert property (rd_acc |=> !hreadyout_o ##1 hreadyout_o)
		else $error("read wait state wrong");
	write_zero_wait_a: assert property (wr_acc |=> hreadyout_o)
		else $error("write stalled");
	wait_only_read_a: assert property (!hreadyout_o |-> $past(rd_acc))
		else $error("wait without read");
	wait_one_cycle_a: assert property ($fell(hreadyout_o) |=> $rose(hreadyout_o))
		else $error("wait longer than one cycle");
	rdata_holds_a: assert property
		($changed(hrdata_o) |-> $past(!hreadyout_o) || $past(sys_rst_i))
		else $error("read data moved outside a read");
	ctl_reads_zero_a: assert property
		(rd_acc && (haddr_i[7:2] == 6'h00 || haddr_i[7:2] > 6'h07)
		|-> ##2 hrdata_o == 32'h0)
		else $error("command or unmapped read not zero");
	reset_idle_a: assert property (disable iff (1'b0)
		sys_rst_i |=> hreadyout_o && hrdata_o == 32'h0)
		else $error("bus not idle after reset");
	cover property (rd_acc);
	cover property (wr_acc && haddr_i[7:0] == 8'h00);
	cover property ($fell(hreadyout_o));
endmodule // csac_chk

bind csac_top csac_chk csac_chk_inst (.clk_i, .sys_rst_i, .hsel_i, .haddr_i,
	.htrans_i, .hwrite_i, .hsize_i, .hwdata_i, .hready_i, .hrdata_o,
	.hreadyout_o, .hresp_o);

// [dv/csac_rdr.sv]
// ahb-lite master model standing for the card reader
module csac_rdr (
	// clock
	input  logic        clk_i,
	// ahb-lite master side
	output logic        hsel_o,
	output logic [31:0] haddr_o,
	output logic [1:0]  htrans_o,
	output logic        hwrite_o,
	output logic [31:0] hwdata_o,
	input  logic        hready_i,
	input  logic [31:0] hrdata_i
);
	timeunit 1ns;
	timeprecision 100ps;
	initial
	begin
		hsel_o = 1'b0;
		haddr_o = 32'h0;
		htrans_o = 2'h0;
		hwrite_o = 1'b0;
		hwdata_o = 32'h0;
	end
	// single word transfer, entered just after a rising edge
	task automatic xfer(input logic w, input logic [31:0] a,
		input logic [31:0] d, output logic [31:0] q);
		hsel_o <= 1'b1;
		htrans_o <= 2'h2;
		haddr_o <= a;
		hwrite_o <= w;
		do @(posedge clk_i); while (hready_i !== 1'b1);
		htrans_o <= 2'h0;
		hwdata_o <= d;
		do @(posedge clk_i); while (hready_i !== 1'b1);
		q = hrdata_i;
	endtask
	// key is loaded, low word then high word, before a login to a sector
	task automatic login_key(input logic [47:0] k);
		logic [31:0] q;
		xfer(1'b1, 32'h08, k[31:0], q);
		xfer(1'b1, 32'h0C, {16'h0, k[47:32]}, q);
	endtask
endmodule // csac_rdr

// [dv/card_sector_access_control_tb.sv]
// self-checking bench for csac_top
module card_sector_access_control_tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam [127:0] SER = 128'hA5A5_0F0F_1234_5678_9ABC_DEF0_0011_2233;
	localparam [127:0] VB = 128'hFE01_FE01_0000_0005_FFFF_FFFA_0000_0005;
	logic        clk_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hready;
	logic [31:0] q;
	int          err_total = 0;
	int          checks_done = 0;
	always #5 clk_i = ~clk_i;
	csac_top #(.SERIAL_BLK(SER)) csac_top_inst (.clk_i, .sys_rst_i,
		.hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
		.hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
		.hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o());
	csac_rdr rdr (.clk_i, .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans),
		.hwrite_o(hwrite), .hwdata_o(hwdata), .hready_i(hready),
		.hrdata_i(hrdata));
	task automatic final_report;
		$display("checks %0d, errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			err_total++;
			$display("unexpected %s: expected %h, seen %h", n, e, g);
		end
	endtask
	function automatic logic [31:0] mk(input logic [2:0] op,
		input logic [5:0] b, input logic ks, input logic [5:0] d);
		return {2'h0, d, 7'h0, ks, 2'h0, b, 5'h0, op};
	endfunction
	// command, then status error code and ok flag
	task automatic cmd(input logic [31:0] w, input logic [3:0] e);
		rdr.xfer(1'b1, 32'h00, w, q);
		rdr.xfer(1'b0, 32'h04, 32'h0, q);
		chk("stat err", {28'h0, e}, {28'h0, q[19:16]});
		chk("stat ok", {31'h0, e == 4'h0}, {31'h0, q[1]});
		chk("fail", {31'h0, e != 4'h0}, {31'h0, q[2]});
	endtask
	task automatic put(input logic [127:0] v);
		for (int i = 0; i < 4; i++)
			rdr.xfer(1'b1, 32'h10 + 4 * i, v[32 * i +: 32], q);
	endtask
	task automatic get(input logic [127:0] v);
		for (int i = 0; i < 4; i++)
		begin
			rdr.xfer(1'b0, 32'h10 + 4 * i, 32'h0, q);
			chk("block word", v[32 * i +: 32], q);
		end
	endtask
	initial
	begin
		repeat (5) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		rdr.xfer(1'b0, 32'h00, 32'h0, q);
		chk("cmd read", 32'h0, q);
		rdr.xfer(1'b0, 32'h04, 32'h0, q);
		chk("auth after reset", 32'h0, {31'h0, q[3]});
		cmd(mk(3'h1, 6'd1, 1'b0, 6'd0), 4'h1);
		rdr.login_key(48'hFFFF_FFFF_FFFF);
		cmd(mk(3'h0, 6'd3, 1'b1, 6'd0), 4'h3);
		cmd(mk(3'h0, 6'd3, 1'b0, 6'd0), 4'h0);
		cmd(mk(3'h1, 6'd0, 1'b0, 6'd0), 4'h0);
		get(SER);
		cmd(mk(3'h2, 6'd0, 1'b0, 6'd0), 4'h2);
		cmd(mk(3'h1, 6'd3, 1'b0, 6'd0), 4'h0);
		get(128'hFFFF_FFFF_FFFF_6980_07FF_0000_0000_0000);
		for (int op = 3; op < 6; op++)
			cmd(mk(op[2:0], 6'd3, 1'b0, 6'd3), 4'h6);
		cmd(mk(3'h1, 6'd4, 1'b0, 6'd0), 4'h1);
		cmd(mk(3'h7, 6'd1, 1'b0, 6'd0), 4'h6);
		put(VB);
		cmd(mk(3'h2, 6'd1, 1'b0, 6'd0), 4'h0);
		put(128'h0);
		cmd(mk(3'h1, 6'd1, 1'b0, 6'd0), 4'h0);
		get(VB);
		rdr.xfer(1'b1, 32'h10, 32'h3, q);
		cmd(mk(3'h3, 6'd1, 1'b0, 6'd2), 4'h0);
		cmd(mk(3'h1, 6'd2, 1'b0, 6'd0), 4'h0);
		get(128'hFE01_FE01_0000_0008_FFFF_FFF7_0000_0008);
		put(128'h1122_3344_5566_FF8F_7708_FFFF_FFFF_FFFF);
		cmd(mk(3'h2, 6'd3, 1'b0, 6'd0), 4'h0);
		rdr.login_key(48'h1122_3344_5566);
		cmd(mk(3'h0, 6'd3, 1'b1, 6'd0), 4'h0);
		chk("auth key", 32'h1, {31'h0, q[4]});
		cmd(mk(3'h1, 6'd3, 1'b0, 6'd0), 4'h0);
		get(128'h0000_0000_0000_FF8F_7708_0000_0000_0000);
		put(128'h1122_3344_5566_FF88_7778_FFFF_FFFF_FFFF);
		cmd(mk(3'h2, 6'd3, 1'b1, 6'd0), 4'h0);
		cmd(mk(3'h3, 6'd1, 1'b0, 6'd2), 4'h2);
		put(128'hFFFF_FFFF_FFFF_6980_FFFF_FFFF_FFFF_FFFF);
		cmd(mk(3'h2, 6'd3, 1'b0, 6'd0), 4'h0);
		cmd(mk(3'h0, 6'd3, 1'b0, 6'd0), 4'h4);
		final_report();
	end
	initial
	begin
		repeat (20000) @(posedge clk_i);
		err_total++;
		final_report();
	end
endmodule // card_sector_access_control_tb
